// File: rcs_top.sv
/*
 reset cause register and stop / halt sequencing for an 8-bit core.
 assumes: avalon-mm slave on SYS_CLK; event inputs are one-cycle pulses
 from logic on SYS_CLK; supply and enable levels are asynchronous and
 are synchronised here.
*/
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
//
// Behaviour
// - reading cause register clears top four flags
// - power-on flag set by power/brownout, cleared otherwise
// - recovery flag set by wake, cleared by power/watchdog
// - recovery plus watchdog means watchdog-caused wake
// - watchdog flag set on timeout, cleared by power/pin-wake
// - pin reset flag set by pin, cleared power/pin-wake
// - bit zero mirrors live low supply level
// - bits three to one read zero
// - each reset sets only its own flag
// - debug resets set only the power-on flag
// - pin wake sets recovery; watchdog wake sets both
// - cause register read-only at ff0, write-only twin
// - stop halts oscillators, clock, core, releases crystal
// - stop keeps watchdog, secondary oscillator, stop timers
// - stop keeps brownout, supply, amps only if enabled
// - stop is left only through wake recovery or a power/pin reset
// - halt stops core, clocks and peripherals keep running
// - halt ends on interrupt, watchdog, reset sources
// - each peripheral disableable in normal run; brownout and supply share one bit
// - wake holds core reset four oscillator cycles
// - after wake internal oscillator enabled and selected
module rcs_top
   import rcs_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic               SYS_CLK,
   input  wire logic               RESET,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0]  ADDRESS,
   input  wire logic               READ,
   input  wire logic               WRITE,
   input  wire logic [31:0]        WRITEDATA,
   input  wire logic [3:0]         BYTEENABLE,
   output logic      [31:0]        READDATA,
   output logic                    WAITREQUEST,
   // core instructions and wake events
   input  wire logic               STOP_EXEC,
   input  wire logic               HALT_EXEC,
   input  wire logic               INTERRUPT,
   input  wire rcs_pkg::event_type EVENTS,
   // asynchronous levels
   input  wire logic               LOW_SUPPLY,
   input  wire logic               WATCHDOG_ENABLE,
   input  wire logic               SECONDARY_ENABLE,
   input  wire logic               TIMER_STOP_ENABLE,
   input  wire logic               BROWNOUT_STOP_OPTION,
   // controls toward the chip
   output rcs_pkg::power_ctl_type  POWER_CTL,
   output logic      [7:0]         PERIPH_OFF,
   output logic      [4:0]         MODE
);
   import rcs_pkg::*;

   // synchronisers for asynchronous levels, first stage read only by second
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else begin
         sync1_q <= {LOW_SUPPLY, WATCHDOG_ENABLE, SECONDARY_ENABLE,
                     TIMER_STOP_ENABLE, BROWNOUT_STOP_OPTION};
         sync2_q <= sync1_q;
      end
   end
   wire low_supply_s = sync2_q[4];
   wire wdog_en_s    = sync2_q[3];
   wire sec_en_s     = sync2_q[2];
   wire tmr_en_s     = sync2_q[1];
   wire bo_stop_s    = sync2_q[0];

   // mode sequencer state
   mode_type mode_q;
   mode_type mode_d;
   logic [2:0] hold_q;
   logic [2:0] hold_d;
   logic [3:0] flags_q;
   logic [3:0] flags_d;
   logic [7:0] periph_q;
   logic [7:0] periph_d;
   logic       osc_sel_q;
   logic       osc_sel_d;
   logic [31:0] rdata_q;
   logic        ack_q;

   // bus decode; one wait cycle then answer, registered data
   wire req       = READ | WRITE;
   wire sel_cause = (ADDRESS == CAUSE_ADDR);
   wire sel_per   = (ADDRESS == PERIPH_ADDR);
   wire sel_state = (ADDRESS == STATE_ADDR);
   wire take      = req & ~ack_q;
   wire rd_cause  = take & READ & sel_cause;
   // write-only twin at the cause address is accepted and discarded
   wire wr_per    = take & WRITE & sel_per & BYTEENABLE[0];
   assign WAITREQUEST = req & ~ack_q;

   // event decode
   wire ev_power  = EVENTS.power_on | EVENTS.brownout_reset |
                    EVENTS.debug_reset |
                    (EVENTS.debug_pin_low & (mode_q == STOP_S));
   wire ev_pin    = EVENTS.pin_reset;
   wire in_stop   = (mode_q == STOP_S);
   wire ev_wdog   = EVENTS.watchdog_reset & ~in_stop;
   wire wake_pin  = in_stop & EVENTS.wake_pin;
   wire wake_wdog = in_stop & EVENTS.wake_watchdog;
   wire wake_oth  = in_stop & EVENTS.wake_other;
   wire wake_any  = wake_pin | wake_wdog | wake_oth;
   wire any_reset = ev_power | ev_pin | ev_wdog;

   // flag next state: read clears first, events then override
   always_comb begin
      flags_d = flags_q;
      if (rd_cause) begin
         flags_d = 4'h0;
      end
      // set dominates clear-on-read
      if (ev_power) begin
         flags_d = 4'b1000;
      end else if (ev_pin) begin
         flags_d = 4'b0001;
      end else if (ev_wdog) begin
         flags_d = 4'b0010;
      end else if (wake_wdog) begin
         flags_d = 4'b0110;
      end else if (wake_pin) begin
         flags_d = 4'b0100;
      end else if (wake_oth) begin
         flags_d = {1'b0, 1'b1, flags_q[1:0] & {2{~rd_cause}}};
      end
   end

   // peripheral disables, byte-lane write
   always_comb begin
      periph_d = periph_q;
      if (wr_per) begin
         periph_d = WRITEDATA[7:0] & 8'h9b;
      end
   end

   // mode sequencing
   always_comb begin
      mode_d    = mode_q;
      hold_d    = hold_q;
      osc_sel_d = osc_sel_q;
      case (mode_q)
         RUN_S: begin
            if (STOP_EXEC) begin
               mode_d = STOP_S;
            end else if (HALT_EXEC) begin
               mode_d = HALT_S;
            end
         end
         HALT_S: begin
            if (INTERRUPT | EVENTS.watchdog_reset | EVENTS.wake_watchdog
                | any_reset) begin
               mode_d = RESYNC_S;
               hold_d = 3'(RESYNC_CYCLES);
            end
         end
         STOP_S: begin
            // only a wake or a true system reset leaves stop
            if (wake_any) begin
               mode_d    = WAKE_S;
               hold_d    = 3'(WAKE_HOLD_CYCLES);
               osc_sel_d = 1'b1;
            end
         end
         WAKE_S: begin
            hold_d = hold_q - 3'd1;
            if (hold_q == 3'd1) begin
               mode_d = RESYNC_S;
               hold_d = 3'(RESYNC_CYCLES);
            end
         end
         RESYNC_S: begin
            hold_d = hold_q - 3'd1;
            if (hold_q == 3'd1) begin
               mode_d = RUN_S;
            end
         end
         default: begin
            mode_d = RUN_S;
         end
      endcase
      if (any_reset) begin
         mode_d    = RESYNC_S;
         hold_d    = 3'(RESYNC_CYCLES);
         osc_sel_d = 1'b1;
      end
   end

   // state registers
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         mode_q    <= RUN_S;
         hold_q    <= 3'h0;
         flags_q   <= FLAGS_RESET;
         periph_q  <= PERIPH_RESET;
         osc_sel_q <= 1'b1;
      end else begin
         mode_q    <= mode_d;
         hold_q    <= hold_d;
         flags_q   <= flags_d;
         periph_q  <= periph_d;
         osc_sel_q <= osc_sel_d;
      end
   end

   // read mux; live supply bit, reserved zero
   wire [7:0] cause_val = {flags_q, 3'b000, low_supply_s};
   wire [31:0] rmux = sel_cause ? {24'h00_0000, cause_val} :
                      sel_per   ? {24'h00_0000, periph_q} :
                      sel_state ? {27'h000_0000, mode_q} : 32'h0000_0000;

   // bus answer registers
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q   <= take;
         rdata_q <= (take & READ) ? rmux : rdata_q;
      end
   end
   assign READDATA = rdata_q;

   // power control outputs
   wire stopped = in_stop | (mode_q == WAKE_S);
   wire run_en  = ~stopped;
   assign POWER_CTL.primary_osc_en   = run_en;
   assign POWER_CTL.internal_osc_en  = run_en | (mode_q == WAKE_S);
   assign POWER_CTL.internal_osc_sel = osc_sel_q;
   assign POWER_CTL.sys_clk_en       = run_en;
   assign POWER_CTL.core_run         = (mode_q == RUN_S);
   assign POWER_CTL.core_reset       = (mode_q == WAKE_S) |
                                       (mode_q == RESYNC_S);
   assign POWER_CTL.crystal_release  = in_stop;
   assign POWER_CTL.watchdog_en      = wdog_en_s;
   assign POWER_CTL.secondary_osc_en = sec_en_s;
   assign POWER_CTL.stop_timer_en    = in_stop & tmr_en_s & sec_en_s;
   assign POWER_CTL.brownout_en      = ~periph_q[SUPPLY_OFF_BIT] &
                                       (~stopped | bo_stop_s);
   assign POWER_CTL.low_supply_en    = ~periph_q[SUPPLY_OFF_BIT];
   assign POWER_CTL.amp_en           = ~periph_q[AMP_OFF_BIT];
   assign POWER_CTL.cmp0_en          = ~periph_q[CMP0_OFF_BIT];
   assign POWER_CTL.cmp1_en          = ~periph_q[CMP1_OFF_BIT];
   assign POWER_CTL.temp_en          = ~periph_q[TEMP_OFF_BIT] & run_en;
   assign POWER_CTL.periph_idle      = stopped;
   assign PERIPH_OFF = periph_q;
   assign MODE       = mode_q;
endmodule
`default_nettype wire

// File: rcs_pkg.sv
/*
 package for the reset cause and sleep control block: register offsets,
 field positions, reset values, timing counts and carrier types.
 assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package rcs_pkg;
   // register byte addresses on the avalon bus
   localparam logic [11:0] CAUSE_ADDR     = 12'h0ff0;
   localparam logic [11:0] PERIPH_ADDR    = 12'h0ff4;
   localparam logic [11:0] STATE_ADDR     = 12'h0ff8;
   // cause register field positions
   localparam int POWER_ON_BIT  = 7;
   localparam int RECOVERY_BIT  = 6;
   localparam int WATCHDOG_BIT  = 5;
   localparam int PIN_RESET_BIT = 4;
   localparam int LOW_SUPPLY_BIT = 0;
   // peripheral disable field positions
   localparam int AMP_OFF_BIT   = 7;
   localparam int SUPPLY_OFF_BIT = 4;
   localparam int TEMP_OFF_BIT  = 3;
   localparam int CMP0_OFF_BIT  = 1;
   localparam int CMP1_OFF_BIT  = 0;
   // reset values
   localparam logic [3:0] FLAGS_RESET  = 4'h8;
   localparam logic [7:0] PERIPH_RESET = 8'h80;
   // core held in reset for this many internal oscillator cycles
   localparam int WAKE_HOLD_CYCLES = 4;
   localparam int RESYNC_CYCLES    = 2;

   // reset and wake events presented in one bundle
   typedef struct packed {
      logic power_on;
      logic brownout_reset;
      logic pin_reset;
      logic watchdog_reset;
      logic debug_reset;
      logic debug_pin_low;
      logic wake_pin;
      logic wake_watchdog;
      logic wake_other;
   } event_type;

   // clock and function enables toward the rest of the chip
   typedef struct packed {
      logic primary_osc_en;
      logic internal_osc_en;
      logic internal_osc_sel;
      logic sys_clk_en;
      logic core_run;
      logic core_reset;
      logic crystal_release;
      logic watchdog_en;
      logic secondary_osc_en;
      logic stop_timer_en;
      logic brownout_en;
      logic low_supply_en;
      logic amp_en;
      logic cmp0_en;
      logic cmp1_en;
      logic temp_en;
      logic periph_idle;
   } power_ctl_type;

   typedef enum logic [4:0] {
      RUN_S    = 5'b0_0001,
      HALT_S   = 5'b0_0010,
      STOP_S   = 5'b0_0100,
      WAKE_S   = 5'b0_1000,
      RESYNC_S = 5'b1_0000
   } mode_type;
endpackage
`default_nettype wire

// File: rcs_top_properties.sv
/*
 checker for rcs_top: cause register reads, stop, wake and halt.
 assumes rcs_pkg is compiled first; attached to rcs_top by bind.
*/
`timescale 1ns/100ps
`default_nettype none
module rcs_top_checker
   import rcs_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic                  SYS_CLK,
   input wire logic                  RESET,
   // register bus
   input wire logic [ADDR_W-1:0]     ADDRESS,
   input wire logic                  READ,
   input wire logic [31:0]           READDATA,
   input wire logic                  WAITREQUEST,
   // sleep, events and controls
   input wire logic                  STOP_EXEC,
   input wire logic                  INTERRUPT,
   input wire rcs_pkg::event_type    EVENTS,
   input wire logic                  LOW_SUPPLY,
   input wire rcs_pkg::power_ctl_type POWER_CTL,
   input wire logic [4:0]            MODE
);
   logic [2:0] ls_cnt_q;
   logic       ls_last_q;
   wire        done = READ && !WAITREQUEST && ADDRESS == CAUSE_ADDR;

   // supply level age; the sync flops need a few quiet cycles
   always_ff @(posedge SYS_CLK) begin
      ls_last_q <= LOW_SUPPLY;
      if (RESET || LOW_SUPPLY != ls_last_q)
         ls_cnt_q <= 3'h0;
      else if (ls_cnt_q != 3'h7)
         ls_cnt_q <= ls_cnt_q + 3'h1;
   end

   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   property p_reserved; done |-> READDATA[3:1] == 3'h0; endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved cause bits not zero");
   property p_clear; (done && $past(EVENTS) == '0 && EVENTS == '0) ##1
      (EVENTS == '0)[*2] ##1 done |-> READDATA[7:4] == 4'h0; endproperty
   a_clear: assert property (p_clear)
      else $error("flags survived a cause read");
   property p_supply; done && ls_cnt_q == 3'h7 |-> READDATA[0] == LOW_SUPPLY;
   endproperty
   a_supply: assert property (p_supply)
      else $error("low supply bit not live");
   property p_stop_in; STOP_EXEC && MODE == RUN_S && EVENTS == '0
      |=> MODE == STOP_S; endproperty
   a_stop_in: assert property (p_stop_in)
      else $error("stop not entered");
   property p_stop_off; MODE == STOP_S |-> !POWER_CTL.sys_clk_en &&
      !POWER_CTL.core_run && !POWER_CTL.primary_osc_en &&
      POWER_CTL.crystal_release; endproperty
   a_stop_off: assert property (p_stop_off)
      else $error("clock or core alive in stop");
   property p_stop_hold; MODE == STOP_S && EVENTS == '0 |=> MODE == STOP_S;
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("stop left without wake");
   property p_wake; $rose(MODE == WAKE_S) |->
      (POWER_CTL.core_reset && MODE == WAKE_S)[*4] ##1
      (POWER_CTL.core_reset && MODE == RESYNC_S)[*2] ##1 MODE == RUN_S;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake hold sequence wrong");
   property p_wake_osc; $fell(MODE == WAKE_S) |->
      POWER_CTL.internal_osc_en && POWER_CTL.internal_osc_sel; endproperty
   a_wake_osc: assert property (p_wake_osc)
      else $error("internal oscillator not selected");
   property p_halt; MODE == HALT_S |-> !POWER_CTL.core_run &&
      POWER_CTL.sys_clk_en && POWER_CTL.primary_osc_en &&
      !POWER_CTL.periph_idle; endproperty
   a_halt: assert property (p_halt)
      else $error("halt controls wrong");
   property p_halt_out; MODE == HALT_S && INTERRUPT |-> ##[1:3] MODE != HALT_S;
   endproperty
   a_halt_out: assert property (p_halt_out)
      else $error("halt not left on interrupt");
endmodule

bind rcs_top rcs_top_checker #(.ADDR_W(ADDR_W)) checker_inst (.SYS_CLK,
   .RESET, .ADDRESS, .READ, .READDATA, .WAITREQUEST, .STOP_EXEC, .INTERRUPT,
   .EVENTS, .LOW_SUPPLY, .POWER_CTL, .MODE);
`default_nettype wire

// File: core_model.sv
/*
 processor core model: avalon-mm master and sleep instruction pulses.
 assumes a slave that answers by dropping WAITREQUEST.
*/
`timescale 1ns/100ps
`default_nettype none
module core_model (
   // clock
   input  wire logic        SYS_CLK,
   // avalon-mm master
   output var  logic [11:0] ADDRESS,
   output var  logic        READ,
   output var  logic        WRITE,
   output var  logic [31:0] WRITEDATA,
   output var  logic [3:0]  BYTEENABLE,
   input  wire logic [31:0] READDATA,
   input  wire logic        WAITREQUEST,
   // sleep instructions
   output var  logic        STOP_EXEC,
   output var  logic        HALT_EXEC
);
   // idle bus at time zero
   initial begin
      ADDRESS = 12'h000;
      READ = 1'b0;
      WRITE = 1'b0;
      WRITEDATA = 32'h0000_0000;
      BYTEENABLE = 4'h1;
      STOP_EXEC = 1'b0;
      HALT_EXEC = 1'b0;
   end

   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      ADDRESS <= a;
      READ <= !wr;
      WRITE <= wr;
      WRITEDATA <= d;
      @(posedge SYS_CLK);
      // only the bench's own timeout ends this wait
      while (WAITREQUEST !== 1'b0) begin
         @(posedge SYS_CLK);
      end
      q = READDATA;
      READ <= 1'b0;
      WRITE <= 1'b0;
      ADDRESS <= ~a;  // released lines never keep the last value
      WRITEDATA <= ~d;
      @(posedge SYS_CLK);
   endtask

   // one-cycle instruction pulse, halt when stop is low
   task automatic sleep(input logic stop);
      STOP_EXEC <= stop;
      HALT_EXEC <= !stop;
      @(posedge SYS_CLK);
      STOP_EXEC <= 1'b0;
      HALT_EXEC <= 1'b0;
      @(posedge SYS_CLK);
   endtask
endmodule
`default_nettype wire

// File: testbench.sv
/*
 testbench for rcs_top: table of reset and wake events, then hand tests.
 assumes rcs_pkg, the checker bind and core_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import rcs_pkg::*;
   // row: enter stop first, event, expected cause byte
   typedef struct packed {
      logic       stop;
      event_type  ev;
      logic [7:0] exp;
   } row_type;
   localparam row_type ROWS [9] = '{'{1'b0, 9'h100, 8'h80},
      '{1'b0, 9'h080, 8'h80}, '{1'b0, 9'h040, 8'h10}, '{1'b0, 9'h020, 8'h20},
      '{1'b0, 9'h010, 8'h80}, '{1'b1, 9'h008, 8'h80}, '{1'b1, 9'h004, 8'h40},
      '{1'b1, 9'h002, 8'h60}, '{1'b1, 9'h001, 8'h40}};
   logic          sys_clk = 1'b0;
   logic          reset = 1'b1;
   logic          interrupt = 1'b0;
   logic          low_supply = 1'b0;
   // enable levels as nets of the bench, so they can be moved per test
   logic          wdog_enable = 1'b1;
   logic          sec_enable = 1'b1;
   logic          tmr_stop_enable = 1'b1;
   logic          bo_stop_option = 1'b0;
   event_type     events = '0;
   logic [11:0]   address;
   logic [31:0]   writedata, readdata, q;
   logic [3:0]    byteenable;
   logic          read, write, waitrequest, stop_exec, halt_exec;
   power_ctl_type power_ctl;
   logic [7:0]    periph_off;
   logic [4:0]    mode;
   int            mismatches = 0;
   int            check_count = 0;
   int            cycles = 0;

   always #20 sys_clk = ~sys_clk;

   // design and the core that drives it
   rcs_top #(.ADDR_W(12)) DUT (.SYS_CLK(sys_clk), .RESET(reset),
      .ADDRESS(address), .READ(read), .WRITE(write), .WRITEDATA(writedata),
      .BYTEENABLE(byteenable), .READDATA(readdata), .WAITREQUEST(waitrequest),
      .STOP_EXEC(stop_exec), .HALT_EXEC(halt_exec), .INTERRUPT(interrupt),
      .EVENTS(events), .LOW_SUPPLY(low_supply),
      .WATCHDOG_ENABLE(wdog_enable), .SECONDARY_ENABLE(sec_enable),
      .TIMER_STOP_ENABLE(tmr_stop_enable),
      .BROWNOUT_STOP_OPTION(bo_stop_option), .POWER_CTL(power_ctl),
      .PERIPH_OFF(periph_off), .MODE(mode));
   core_model core (.SYS_CLK(sys_clk), .ADDRESS(address), .READ(read),
      .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(byteenable),
      .READDATA(readdata), .WAITREQUEST(waitrequest), .STOP_EXEC(stop_exec),
      .HALT_EXEC(halt_exec));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] v;
      core.xfer(1'b0, a, 32'h0000_0000, v);
      chk(v, e);
   endtask

   task automatic pulse(input event_type e);
      events <= e;
      @(posedge sys_clk);
      events <= '0;
      @(posedge sys_clk);
   endtask

   // bounded wait for the core to be running again
   task automatic wait_run();
      int n;
      n = 0;
      while (mode !== RUN_S && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      chk(32'(mode), 32'(RUN_S));
   endtask

   // hang guard, far above the few hundred cycles needed
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         stop_test();
      end
   end

   initial begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      chk(32'(periph_off), 32'h0000_0080);
      rd(CAUSE_ADDR, 32'h0000_0080);
      rd(CAUSE_ADDR, 32'h0000_0000);
      core.xfer(1'b1, CAUSE_ADDR, 32'h0000_00ff, q);
      rd(CAUSE_ADDR, 32'h0000_0000);
      rd(12'h100, 32'h0000_0000);
      core.xfer(1'b1, PERIPH_ADDR, 32'h0000_00ff, q);
      chk(32'(periph_off), 32'h0000_009b);
      foreach (ROWS[i]) begin
         core.xfer(1'b0, CAUSE_ADDR, 32'h0000_0000, q);
         if (ROWS[i].stop) begin
            core.sleep(1'b1);
            repeat (5) @(posedge sys_clk);
            chk(32'(mode), 32'(STOP_S));
            chk(32'({power_ctl.watchdog_en, power_ctl.secondary_osc_en,
               power_ctl.stop_timer_en}), 32'h0000_0007);
         end
         pulse(ROWS[i].ev);
         wait_run();
         rd(CAUSE_ADDR, 32'(ROWS[i].exp));
      end
      // unread flags: pin reset clears power-on, watchdog clears pin, pin wake clears watchdog
      pulse(9'h100);
      wait_run();
      pulse(9'h040);
      wait_run();
      pulse(9'h020);
      wait_run();
      core.sleep(1'b1);
      pulse(9'h004);
      wait_run();
      pulse(9'h020);
      wait_run();
      rd(CAUSE_ADDR, 32'h0000_0020);
      core.sleep(1'b0);
      chk(32'(mode), 32'(HALT_S));
      interrupt <= 1'b1;
      wait_run();
      interrupt <= 1'b0;
      core.sleep(1'b0);
      pulse(9'h040);
      wait_run();
      rd(CAUSE_ADDR, 32'h0000_0010);
      low_supply <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rd(CAUSE_ADDR, 32'h0000_0001);
      rd(CAUSE_ADDR, 32'h0000_0001);
      low_supply <= 1'b0;
      repeat (8) @(posedge sys_clk);
      // event on the very edge that takes the clearing read
      fork
         core.xfer(1'b0, CAUSE_ADDR, 32'h0000_0000, q);
         pulse(9'h100);
      join
      wait_run();
      rd(CAUSE_ADDR, 32'h0000_0080);
      stop_test();
   end
endmodule
`default_nettype wire
